/* File: rtl/bbsr_fifo.v */
// synchronous fifo, valid/ready on both sides
// assumes one clock, sync active-high reset
`timescale 1ns/1ps

module bbsr_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
)
(
   input  wire             i_clk,     // system clock
   input  wire             i_rst,     // sync reset, high
   input  wire             i_valid,   // write request
   output wire             o_ready,   // not full
   input  wire [WIDTH-1:0] i_data,    // write data
   output wire             o_valid,   // not empty
   input  wire             i_ready,   // read accept
   output wire [WIDTH-1:0] o_data     // head word
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ff;
   reg [AW-1:0]    rd_ff;
   reg [AW:0]      cnt_ff;
   wire            push;
   wire            pop;

   // ---------------------------------------------------------------
   // flags and handshakes
   // ---------------------------------------------------------------
   assign o_ready = (cnt_ff != DEPTH[AW:0]);
   assign o_valid = (cnt_ff != {(AW+1){1'b0}});
   assign push    = i_valid & o_ready;
   assign pop     = o_valid & i_ready;
   assign o_data  = mem[rd_ff];

   // storage write
   always @(posedge i_clk)
   begin
      if (push)
      begin
         mem[wr_ff] <= i_data;
      end
   end

   // pointers and fill count
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wr_ff  <= {AW{1'b0}};
         rd_ff  <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wr_ff <= wr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ff <= rd_ff + 1'b1;
         end
         if (push && !pop)
         begin
            cnt_ff <= cnt_ff + 1'b1;
         end
         else if (pop && !push)
         begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end

endmodule // bbsr_fifo

/* File: rtl/bbsr_sync3.v */
// three-flop input synchroniser with agreement filter
// assumes the input is asynchronous to i_clk
`timescale 1ns/1ps

module bbsr_sync3
#(
   parameter W = 1
)
(
   input  wire         i_clk,   // system clock
   input  wire         i_rst,   // sync reset, high
   input  wire [W-1:0] i_d,     // async input
   output reg  [W-1:0] o_q      // filtered output
);

   reg [W-1:0] s1_ff;
   reg [W-1:0] s2_ff;
   reg [W-1:0] s3_ff;
   wire [W-1:0] agree;

   // per-bit agreement, so one noisy pin never freezes the others
   assign agree = ~(s2_ff ^ s3_ff);

   // ---------------------------------------------------------------
   // synchroniser chain, each bit updates once its stages agree
   // ---------------------------------------------------------------
   always @(posedge i_clk)
   begin
      if (i_rst)
      begin
         s1_ff <= {W{1'b0}};
         s2_ff <= {W{1'b0}};
         s3_ff <= {W{1'b0}};
         o_q   <= {W{1'b0}};
      end
      else
      begin
         s1_ff <= i_d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         o_q   <= (s3_ff & agree) | (o_q & ~agree);
      end
   end

endmodule // bbsr_sync3

/* File: rtl/bbsr_top.v */
// eight-stage bidirectional bus shift register with serial input
// assumes bus pins and controls arrive from outside the clock domain;
// the word shown on the driven port is staged through an 8-deep fifo
`timescale 1ns/1ps
`include "bbsr_regs.vh"

module bbsr_top
(
   input  wire                   I_CLK_SYS,       // 25 MHz system clock
   input  wire                   I_RST,           // sync reset, high
   input  wire                   I_PORT_A_ENABLE, // port A enable pin
   input  wire                   I_DIR_A_TO_B,    // 1: A to B, 0: B to A
   input  wire                   I_ASYNC_SEL,     // 1: load without clock
   input  wire                   I_PARALLEL_SEL,  // 1: parallel, 0: serial
   input  wire                   I_SHIFT_CLK,     // single-phase shift clock pin
   input  wire                   I_SERIAL_IN,     // serial data pin
   input  wire [`BBSR_WIDTH-1:0] I_PORT_A,        // port A pin level
   output reg  [`BBSR_WIDTH-1:0] O_PORT_A,        // port A drive value
   output reg                    O_PORT_A_OE,     // port A driven
   input  wire [`BBSR_WIDTH-1:0] I_PORT_B,        // port B pin level
   output reg  [`BBSR_WIDTH-1:0] O_PORT_B,        // port B drive value
   output reg                    O_PORT_B_OE,     // port B driven
   output reg  [`BBSR_WIDTH-1:0] O_STORED,        // stored word
   output reg                    O_OUT_STALL      // output fifo full
);

   // ---------------------------------------------------------------
   // synchronised pins
   // ---------------------------------------------------------------
   wire [4:0]             ctl_s;
   wire                   ae;
   wire                   dir;
   wire                   asy;
   wire                   par;
   wire                   sclk;
   wire                   sin;
   wire [`BBSR_WIDTH-1:0] a_s;
   wire [`BBSR_WIDTH-1:0] b_s;

   bbsr_sync3 #(.W(6)) u_sync_ctl
   (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .i_d   ({I_SERIAL_IN, I_SHIFT_CLK, I_PARALLEL_SEL, I_ASYNC_SEL,
               I_DIR_A_TO_B, I_PORT_A_ENABLE}),
      .o_q   ({sin, ctl_s})
   );

   bbsr_sync3 #(.W(2*`BBSR_WIDTH)) u_sync_bus
   (
      .i_clk (I_CLK_SYS),
      .i_rst (I_RST),
      .i_d   ({I_PORT_A, I_PORT_B}),
      .o_q   ({a_s, b_s})
   );

   assign ae   = ctl_s[0];
   assign dir  = ctl_s[1];
   assign asy  = ctl_s[2];
   assign par  = ctl_s[3];
   assign sclk = ctl_s[4];

   // ---------------------------------------------------------------
   // clock edge detect on the filtered shift clock
   // ---------------------------------------------------------------
   reg sclk_d_ff;
   wire rise;

   always @(posedge I_CLK_SYS)
   begin
      if (I_RST)
      begin
         sclk_d_ff <= 1'b0;
      end
      else
      begin
         sclk_d_ff <= sclk;
      end
   end

   assign rise = sclk & ~sclk_d_ff;

   // ---------------------------------------------------------------
   // register stages and next-value selection
   // ---------------------------------------------------------------
   reg  [`BBSR_WIDTH-1:0] word_ff;
   reg  [`BBSR_WIDTH-1:0] nxt_word;
   wire [`BBSR_WIDTH-1:0] load_src;
   wire [`BBSR_WIDTH-1:0] shifted;

   // with port A disabled and direction high, A is ignored: recirculate
   assign load_src = dir ? (ae ? a_s : word_ff) : b_s;

   // stage i takes stage i-1, stage 0 takes the serial bit
   genvar gi;
   generate
      for (gi = 0; gi < `BBSR_WIDTH; gi = gi + 1)
      begin : g_stage
         if (gi == 0)
         begin : g_first
            assign shifted[gi] = sin;
         end
         else
         begin : g_rest
            assign shifted[gi] = word_ff[gi-1];
         end
      end
   endgenerate

   always @*
   begin
      nxt_word = word_ff;
      if (!par)
      begin
         if (rise)
         begin
            nxt_word = shifted;
         end
      end
      else if (asy)
      begin
         nxt_word = load_src;
      end
      else if (rise)
      begin
         nxt_word = load_src;
      end
   end

   always @(posedge I_CLK_SYS)
   begin
      if (I_RST)
      begin
         word_ff <= `BBSR_RST_WORD;
      end
      else
      begin
         word_ff <= nxt_word;
      end
   end

   // ---------------------------------------------------------------
   // output word fifo: stages each new stored word toward the ports
   // ---------------------------------------------------------------
   reg  [`BBSR_WIDTH-1:0] last_ff;
   wire                   f_in_rdy;
   wire                   f_out_vld;
   wire [`BBSR_WIDTH-1:0] f_out;
   wire                   chg;

   assign chg = (word_ff != last_ff);

   always @(posedge I_CLK_SYS)
   begin
      if (I_RST)
      begin
         last_ff <= `BBSR_RST_WORD;
      end
      else if (chg && f_in_rdy)
      begin
         last_ff <= word_ff;
      end
   end

   bbsr_fifo #(.WIDTH(`BBSR_WIDTH), .DEPTH(`BBSR_FIFO_DEPTH), .AW(`BBSR_FIFO_AW)) u_fifo
   (
      .i_clk   (I_CLK_SYS),
      .i_rst   (I_RST),
      .i_valid (chg),
      .o_ready (f_in_rdy),
      .i_data  (word_ff),
      .o_valid (f_out_vld),
      .i_ready (1'b1),
      .o_data  (f_out)
   );

   // ---------------------------------------------------------------
   // port drive: outputs change only on system clock edges
   // ---------------------------------------------------------------
   always @(posedge I_CLK_SYS)
   begin
      if (I_RST)
      begin
         O_PORT_A    <= `BBSR_RST_WORD;
         O_PORT_B    <= `BBSR_RST_WORD;
         O_STORED    <= `BBSR_RST_WORD;
         O_PORT_A_OE <= 1'b0;
         O_PORT_B_OE <= 1'b0;
         O_OUT_STALL <= 1'b0;
      end
      else
      begin
         O_PORT_B_OE <= dir;
         O_PORT_A_OE <= ae & ~dir;
         if (f_out_vld)
         begin
            O_PORT_A <= f_out;
            O_PORT_B <= f_out;
            O_STORED <= f_out;
         end
         O_OUT_STALL <= ~f_in_rdy;
      end
   end

endmodule // bbsr_top

/* File: shared/bbsr_regs.vh */
// constants for the bidirectional bus shift register
// assumes a 25 MHz system clock, no register bus, plain control ports
//
// Overview of operation
// - serial, port-A enable low, direction low: shift on clock, both ports undriven.
// - serial, direction high: drive stored word onto port B regardless of port-A enable.
// - serial, port-A enable high, direction low: drive port A while shifting.
// - parallel, enables low, async low: load port B on clock, port A undriven.
// - parallel, enables low, async high: load port B without clock, port A undriven.
// - parallel, A-enable low, direction high, async low: drive B, recirculate on clock.
// - parallel, A-enable low, direction high, async high: drive B, recirculate continuously.
// - parallel, A-enable high, direction low, async low: clocked B load, drive A.
// - parallel, A-enable high, direction low, async high: unclocked B load, drive A.
// - parallel, A-enable high, direction high, async low: clocked A load, drive B.
// - parallel, all three high: unclocked A load, drive B.
// - synchronous cases change outputs only on the clock's rising edge.
// - eight stages forming a static register between the two ports.
// - direction high moves data A to B; low moves B to A.
// - single-phase clock acts only in synchronous operation.
`ifndef BBSR_REGS_VH
`define BBSR_REGS_VH

// ---------------------------------------------------------------
// widths and depths
// ---------------------------------------------------------------
`define BBSR_WIDTH      8
`define BBSR_FIFO_DEPTH 8
`define BBSR_FIFO_AW    3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define BBSR_RST_WORD   8'h00
`define BBSR_RST_SYNC   3'h0

`endif

/* File: testbench/bbsr_bus.sv */
// bus model for one parallel port of the shift register
// assumes one system clock; the design drive wins over outside logic
`timescale 1ns/1ps

module bbsr_bus
(
   input  wire       i_clk,  // system clock
   input  wire       i_oe,   // design drives the bus
   input  wire [7:0] i_dut,  // design drive value
   input  wire       i_en,   // outside logic drives the bus
   input  wire [7:0] i_ext,  // outside drive value
   output reg  [7:0] o_pin   // resolved bus level
);
   // released bus shows the inverse of its last level
   initial
   begin
      o_pin = 8'h00;
   end
   always @(posedge i_clk)
   begin
      o_pin <= i_oe ? i_dut : (i_en ? i_ext : ~o_pin);
   end
endmodule // bbsr_bus

/* File: testbench/bbsr_chk.sv */
// port checker for the bus shift register
// assumes binding onto bbsr_top, one clock, sync reset high
`timescale 1ns/1ps

module bbsr_chk
(
   input wire       I_CLK_SYS,       // system clock
   input wire       I_RST,           // sync reset
   input wire       I_PORT_A_ENABLE, // port A enable
   input wire       I_DIR_A_TO_B,    // direction
   input wire       I_ASYNC_SEL,     // unclocked load
   input wire       I_PARALLEL_SEL,  // parallel mode
   input wire       I_SHIFT_CLK,     // shift clock pin
   input wire       I_SERIAL_IN,     // serial bit
   input wire [7:0] I_PORT_A,        // port A level
   input wire [7:0] I_PORT_B,        // port B level
   input wire       O_PORT_A_OE,     // port A driven
   input wire       O_PORT_B_OE,     // port B driven
   input wire [7:0] O_STORED,        // stored word
   input wire       O_OUT_STALL      // output fifo full
);
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RST);
   // helper terms for the unclocked and idle clocked modes
   wire w_unclk = I_PARALLEL_SEL & I_ASYNC_SEL;
   wire w_idle  = I_PARALLEL_SEL & ~I_ASYNC_SEL & ~I_SHIFT_CLK;
   // bus levels one cycle back, so a load is judged only on a settled bus
   reg [7:0] a_last_ff;
   reg [7:0] b_last_ff;
   always @(posedge I_CLK_SYS)
   begin
      a_last_ff <= I_PORT_A;
      b_last_ff <= I_PORT_B;
   end
   wire w_bh = w_unclk & ~I_DIR_A_TO_B & (I_PORT_B == b_last_ff);
   wire w_ah = w_unclk & I_DIR_A_TO_B & I_PORT_A_ENABLE & (I_PORT_A == a_last_ff);
   // pin rise to shown word: filter, shift, fifo, output register
   property p_shift;
      (!I_PARALLEL_SEL && $rose(I_SHIFT_CLK)) |-> ##7
         (O_STORED[7:1] == $past(O_STORED[6:0], 7)) && (O_STORED[0] == $past(I_SERIAL_IN, 7));
   endproperty
   chk_b_oe_on: assert property (I_DIR_A_TO_B [*8] |-> O_PORT_B_OE)
      else $error("port B not driven");
   chk_b_oe_off: assert property ((!I_DIR_A_TO_B) [*8] |-> !O_PORT_B_OE)
      else $error("port B driven");
   chk_a_oe_on: assert property ((I_PORT_A_ENABLE && !I_DIR_A_TO_B) [*8] |-> O_PORT_A_OE)
      else $error("port A not driven");
   chk_a_oe_off: assert property ((!I_PORT_A_ENABLE || I_DIR_A_TO_B) [*8] |-> !O_PORT_A_OE)
      else $error("port A driven");
   chk_one_driver: assert property (!(O_PORT_A_OE && O_PORT_B_OE))
      else $error("both ports driven");
   chk_hold_idle: assert property (w_idle [*8] ##1 w_idle [*4] |-> $stable(O_STORED))
      else $error("word moved without clock");
   chk_serial_shift: assert property (p_shift)
      else $error("serial shift wrong");
   chk_unclk_b: assert property (w_bh [*8] ##1 w_bh [*4] |-> O_STORED == I_PORT_B)
      else $error("unclocked B load wrong");
   chk_unclk_a: assert property (w_ah [*8] ##1 w_ah [*4] |-> O_STORED == I_PORT_A)
      else $error("unclocked A load wrong");
   chk_no_stall: assert property (!O_OUT_STALL)
      else $error("output fifo stalled");
   cover property (!I_PARALLEL_SEL && $rose(I_SHIFT_CLK));
   cover property (w_unclk && $changed(O_STORED));
   cover property ($rose(O_PORT_B_OE));
endmodule // bbsr_chk

bind bbsr_top bbsr_chk u_bbsr_chk (.*);

/* File: testbench/tb.sv */
// self-checking bench for the bus shift register
// assumes bus models on ports A and B, 25 MHz clock
`timescale 1ns/1ps

module tb;
   reg        clk;      // system clock
   reg        rst;      // sync reset
   reg  [3:0] m;        // {enable, parallel, direction, unclocked}
   reg        sck;      // shift clock pin
   reg        sin;      // serial bit
   reg  [7:0] a_x;      // outside value on A
   reg  [7:0] b_x;      // outside value on B
   wire [7:0] pa;       // port A level
   wire [7:0] pb;       // port B level
   wire [7:0] oa;       // port A drive
   wire [7:0] ob;       // port B drive
   wire [7:0] word;     // stored word
   wire       oea;      // port A driven
   wire       oeb;      // port B driven
   integer    failures; // mismatches
   integer    n_tests;  // comparisons
   integer    i;        // loop index
   wire [7:0] oe = {6'h00, oea, oeb};
   bbsr_top u_bbsr_top (.I_CLK_SYS(clk), .I_RST(rst), .I_PORT_A_ENABLE(m[3]),
      .I_PARALLEL_SEL(m[2]), .I_DIR_A_TO_B(m[1]), .I_ASYNC_SEL(m[0]), .I_SHIFT_CLK(sck),
      .I_SERIAL_IN(sin), .I_PORT_A(pa), .O_PORT_A(oa), .O_PORT_A_OE(oea), .I_PORT_B(pb),
      .O_PORT_B(ob), .O_PORT_B_OE(oeb), .O_STORED(word), .O_OUT_STALL());
   bbsr_bus u_bbsr_bus_a (.i_clk(clk), .i_oe(oea), .i_dut(oa), .i_en(m[3] & m[1]),
      .i_ext(a_x), .o_pin(pa));
   bbsr_bus u_bbsr_bus_b (.i_clk(clk), .i_oe(oeb), .i_dut(ob), .i_en(~m[1]),
      .i_ext(b_x), .o_pin(pb));
   // clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task cyc(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task chk8(input string nm, input [7:0] e, input [7:0] g);
      n_tests = n_tests + 1;
      if (g !== e)
      begin
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
         failures = failures + 1;
      end
   endtask
   // set controls and outside drive, let the filters settle
   task mode(input [3:0] c, input [7:0] a, input [7:0] b);
      @(posedge clk);
      m <= c;
      a_x <= a;
      b_x <= b;
      cyc(12);
   endtask
   task pulse(input s);
      @(posedge clk);
      sck <= 1'b1;
      sin <= s;
      cyc(5);
      sck <= 1'b0;
      cyc(7);
   endtask
   task test_done;
      $display("comparisons %0d, failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task t_serial;
      reg [7:0] v;
      v = 8'ha5;
      mode(4'h0, 8'h00, 8'h00);
      for (i = 7; i >= 0; i = i - 1)
         pulse(v[i]);
      chk8("word", 8'ha5, word);
      chk8("oe", 8'h00, oe);
   endtask
   task t_drive;
      mode(4'h2, 8'h00, 8'h00);
      chk8("port b", 8'ha5, ob);
      mode(4'ha, 8'h00, 8'h00);
      chk8("oe", 8'h01, oe);
      mode(4'h9, 8'h00, 8'h00);
      pulse(1'b1);
      chk8("word", 8'h4b, word);
      chk8("port a", 8'h4b, oa);
   endtask
   task t_sync;
      mode(4'h4, 8'h00, 8'h3c);
      chk8("word", 8'h4b, word);
      pulse(1'b0);
      chk8("word", 8'h3c, word);
      chk8("oe", 8'h00, oe);
      mode(4'hc, 8'h00, 8'hc3);
      chk8("word", 8'h3c, word);
      pulse(1'b0);
      chk8("port a", 8'hc3, oa);
   endtask
   task t_unclk;
      mode(4'h5, 8'h00, 8'h5a);
      chk8("word", 8'h5a, word);
      mode(4'hd, 8'h00, 8'h96);
      chk8("port a", 8'h96, oa);
   endtask
   task t_recirc;
      mode(4'h4, 8'h00, 8'h96);
      mode(4'h6, 8'h11, 8'h00);
      pulse(1'b0);
      chk8("word", 8'h96, word);
      chk8("oe", 8'h01, oe);
      mode(4'h7, 8'h22, 8'h00);
      chk8("port b", 8'h96, ob);
   endtask
   task t_load_a;
      mode(4'he, 8'h33, 8'h00);
      pulse(1'b0);
      chk8("port b", 8'h33, ob);
      mode(4'hf, 8'h44, 8'h00);
      chk8("word", 8'h44, word);
   endtask
   // main sequence
   initial
   begin
      failures = 0;
      n_tests = 0;
      rst = 1'b1;
      m = 4'h0;
      sck = 1'b0;
      sin = 1'b0;
      a_x = 8'h00;
      b_x = 8'h00;
      cyc(4);
      chk8("reset word", 8'h00, word);
      rst <= 1'b0;
      t_serial;
      t_drive;
      t_sync;
      t_unclk;
      t_recirc;
      t_load_a;
      cyc(4);
      test_done;
   end
   // watchdog
   initial
   begin
      #100000;
      failures = failures + 1;
      test_done;
   end
endmodule // tb
